// >>> hdl/guard_pkg.sv
package guard_pkg;
    localparam logic [31:0] CMD_ADDR       = 32'hfffff170;
    localparam logic [31:0] PSAVE_ADDR     = 32'hfffff070;
    localparam logic [31:0] CLKCTL_ADDR    = 32'hfffff072;
    localparam logic [31:0] STATUS_ADDR    = 32'hfffff078;
    localparam int          ERR_BIT        = 4;
    localparam int          LOCK_BIT       = 0;
    localparam logic [7:0]  PSAVE_RESET    = 8'h00;
    localparam logic [7:0]  CLKCTL_RESET   = 8'h00;
    // APB register offsets of the controller.
    localparam logic [11:0] APB_CTRL       = 12'h000;
    localparam logic [11:0] APB_ADDR       = 12'h004;
    localparam logic [11:0] APB_WDATA      = 12'h008;
    localparam logic [11:0] APB_RDATA      = 12'h00c;
    localparam logic [11:0] APB_IRQ_STAT   = 12'h010;
    localparam logic [11:0] APB_IRQ_MASK   = 12'h014;
    localparam int          CTRL_GO        = 0;
    localparam int          CTRL_WRITE     = 1;
    localparam int          CTRL_BITOP     = 2;
    localparam int          CTRL_BUSY      = 8;
    localparam int          IRQ_DONE       = 0;
    localparam int          IRQ_PERR       = 1;
    typedef enum logic [1:0] {
        BOP_STORE = 2'b00,
        BOP_SET   = 2'b01,
        BOP_CLEAR = 2'b10,
        BOP_NOT   = 2'b11
    } bitop_type;
endpackage : guard_pkg

// >>> hdl/periph_store_if.sv
`timescale 1ns/1ps
`default_nettype none
// Peripheral store bus between the CPU side and the guard. A request is a single
// cycle pulse; the guard answers every request in the next cycle with ack.
interface periph_store_if;
    logic        req;
    logic        write;
    logic        isDma;
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic [1:0]  bitOp;
    logic        ack;
    logic [7:0]  rdata;
    logic        irqHold;
    modport device (input req, write, isDma, addr, wdata, wmask, bitOp, output ack, rdata, irqHold);
    modport cpu    (output req, write, isDma, addr, wdata, wmask, bitOp, input ack, rdata, irqHold);
endinterface : periph_store_if
`default_nettype wire

// >>> hdl/protected_register_write_guard.sv
// Notes on behaviour
// R1: Only clock and power-save registers protected.
// R2: CPU stores command, then protected register.
// R3: Any byte value arms the command.
// R4: Command is byte write only; reads harmless.
// R5: Protected registers read freely, no side effects.
// R6: Sticky error flag at status bit 4.
// R7: Unarmed protected write sets the error.
// R8: Armed store elsewhere sets the error.
// R9: Error clears only by writing zero or reset.
// R10: Status bit 0 shows PLL unlocked.
// R11: Status supports byte and bit access.
// R12: No interrupt between command and next store.
// R13: Never write these registers through DMA.
// R14: Same source register for both stores.
// R15: NOP follows a STOP or IDLE store.
// R16: Wake resumes after the following instruction.
// R17: Erroneous write ignored; window closes after one store.
`timescale 1ns/1ps
`default_nettype none
module protected_register_write_guard
    import guard_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    periph_store_if.device bus,
    input  wire logic     pllLockedPin,
    output logic [7:0]    clockControl,
    output logic [7:0]    powerSaveControl,
    output logic          powerSaveWritten
);
    // ==========================================================
    // State
    typedef struct packed {
        logic       armed;
        logic       err;
        logic [7:0] clk;
        logic [7:0] psave;
        logic       ack;
        logic [7:0] rdata;
        logic       pwr;
        logic       lockS1;
        logic       lockS2;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic       isCmd;
    logic       isClk;
    logic       isPs;
    logic       isStat;
    logic       isProt;
    logic       store;
    logic [7:0] oldVal;
    logic [7:0] newVal;

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.lockS1 = pllLockedPin;
        st_nxt.lockS2 = st_r.lockS1;
        isCmd  = bus.addr == CMD_ADDR;
        isClk  = bus.addr == CLKCTL_ADDR;                               // R1
        isPs   = bus.addr == PSAVE_ADDR;                                // R1
        isStat = bus.addr == STATUS_ADDR;
        isProt = isClk | isPs;
        // DMA stores never take part in the sequence; the guard ignores them.
        store  = bus.req & bus.write & ~bus.isDma;                      // R13
        oldVal = isClk ? st_r.clk : isPs ? st_r.psave :
                 {3'h0, st_r.err, 3'h0, ~st_r.lockS2};
        case (bitop_type'(bus.bitOp))                                   // R11
            BOP_SET:   newVal = oldVal | bus.wmask;
            BOP_CLEAR: newVal = oldVal & ~bus.wmask;
            BOP_NOT:   newVal = oldVal ^ bus.wmask;
            default:   newVal = bus.wdata;
        endcase
        st_nxt.ack   = bus.req;
        st_nxt.pwr   = 1'b0;
        st_nxt.rdata = 8'h00;
        if (bus.req & ~bus.write) begin
            if (isClk) st_nxt.rdata = st_r.clk;                         // R5
            else if (isPs) st_nxt.rdata = st_r.psave;                   // R5
            else if (isStat) st_nxt.rdata = oldVal;                     // R10
            else st_nxt.rdata = 8'h00;                                  // R4
        end
        if (store) begin
            st_nxt.armed = 1'b0;                                        // R17
            if (isCmd) begin
                st_nxt.armed = 1'b1;                                    // R3
            end else if (isProt) begin
                if (st_r.armed) begin
                    if (isClk) st_nxt.clk = newVal;
                    if (isPs) begin
                        st_nxt.psave = newVal;
                        st_nxt.pwr   = 1'b1;                            // R16
                    end
                end else begin
                    st_nxt.err = 1'b1;                                  // R7
                end
            end else begin
                if (st_r.armed) st_nxt.err = 1'b1;                      // R8
                if (isStat && !newVal[ERR_BIT] && !(st_r.armed)) st_nxt.err = 1'b0; // R9
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{armed: 1'b0, err: 1'b0, clk: CLKCTL_RESET, psave: PSAVE_RESET,
                      ack: 1'b0, rdata: 8'h00, pwr: 1'b0, lockS1: 1'b0, lockS2: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.ack          = st_r.ack;
    assign bus.rdata        = st_r.rdata;
    assign bus.irqHold      = st_r.armed;                               // R12
    assign clockControl     = st_r.clk;
    assign powerSaveControl = st_r.psave;
    assign powerSaveWritten = st_r.pwr;
endmodule : protected_register_write_guard
`default_nettype wire

// >>> hdl/store_sequencer.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// CPU-side end: software sets address/data over APB and sets GO; a write to a
// protected register is sent as a command store, then the store one cycle after the command's ack.
module store_sequencer
    import guard_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    periph_store_if.cpu      bus
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CMD  = 2'b01,
        S_MAIN = 2'b10,
        S_WAIT = 2'b11
    } phase_type;

    typedef struct packed {
        phase_type   ph;
        logic [2:0]  ctrl;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [7:0]  rdata;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        req;
        logic [31:0] reqAddr;
        logic [31:0] prd;
        logic        irq;
        logic        rdy;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic      acc;
    logic      prot;

    always_comb begin
        st_nxt     = st_r;
        acc        = psel & penable;
        prot       = st_r.addr == CLKCTL_ADDR || st_r.addr == PSAVE_ADDR;
        st_nxt.req = 1'b0;
        st_nxt.prd = 32'h0;
        st_nxt.rdy = acc & ~st_r.rdy;
        // ==========================================================
        // APB registers; one wait state lets read data be registered at the same edge where pready rises.
        if (acc & ~pwrite & ~st_r.rdy) begin
            case (paddr)
                APB_CTRL:     st_nxt.prd = {23'h0, st_r.ph != S_IDLE, 5'h0, st_r.ctrl[2:1], 1'b0};
                APB_ADDR:     st_nxt.prd = st_r.addr;
                APB_WDATA:    st_nxt.prd = st_r.wdata;
                APB_RDATA:    st_nxt.prd = {24'h0, st_r.rdata};
                APB_IRQ_STAT: st_nxt.prd = {30'h0, st_r.stat};
                APB_IRQ_MASK: st_nxt.prd = {30'h0, st_r.mask};
                default:      st_nxt.prd = 32'h0;
            endcase
        end
        if (acc & pwrite & st_r.rdy) begin
            case (paddr)
                APB_CTRL:     st_nxt.ctrl = pwdata[2:0];
                APB_ADDR:     st_nxt.addr = pwdata;
                APB_WDATA:    st_nxt.wdata = pwdata;
                APB_IRQ_STAT: st_nxt.stat = st_r.stat & ~pwdata[1:0];
                APB_IRQ_MASK: st_nxt.mask = pwdata[1:0];
                default:      st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        // ==========================================================
        // Store sequence.
        case (st_r.ph)
            S_IDLE: if (st_r.ctrl[CTRL_GO]) begin
                st_nxt.ctrl[CTRL_GO] = 1'b0;
                st_nxt.req           = 1'b1;
                if (st_r.ctrl[CTRL_WRITE] && prot) begin
                    st_nxt.reqAddr = CMD_ADDR;                          // R2
                    st_nxt.ph      = S_CMD;
                end else begin
                    st_nxt.reqAddr = st_r.addr;
                    st_nxt.ph      = S_WAIT;
                end
            end
            S_CMD: if (bus.ack) begin
                st_nxt.req     = 1'b1;                                  // R2
                st_nxt.reqAddr = st_r.addr;
                st_nxt.ph      = S_WAIT;
            end
            S_WAIT: if (bus.ack) begin
                st_nxt.rdata        = bus.rdata;
                st_nxt.stat[IRQ_DONE] = 1'b1;
                st_nxt.ph           = S_IDLE;
            end
            default: st_nxt.ph = S_IDLE;
        endcase
        // Set wins over a clear in the same cycle.
        if (st_r.ph == S_WAIT && bus.ack) st_nxt.stat[IRQ_DONE] = 1'b1;
        if (bus.ack && st_r.ph == S_WAIT && st_r.ctrl[CTRL_WRITE] && !prot &&
            st_r.addr == STATUS_ADDR && bus.rdata[ERR_BIT]) st_nxt.stat[IRQ_PERR] = 1'b1;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{ph: S_IDLE, ctrl: 3'h0, addr: 32'h0, wdata: 32'h0, rdata: 8'h00,
                      stat: 2'h0, mask: 2'h0, req: 1'b0, reqAddr: 32'h0, prd: 32'h0, irq: 1'b0,
                      rdy: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata    = st_r.prd;
    assign pready    = st_r.rdy;
    assign pslverr   = 1'b0;
    assign irq       = st_r.irq;
    assign bus.req   = st_r.req;
    assign bus.addr  = st_r.reqAddr;
    // Command and main store carry the same data byte; the command store always uses BOP_STORE.
    assign bus.write = st_r.ctrl[CTRL_WRITE] | (st_r.ph == S_CMD);      // R14
    assign bus.isDma = 1'b0;
    assign bus.wdata = st_r.wdata[7:0];
    assign bus.wmask = st_r.wdata[15:8];
    assign bus.bitOp = (st_r.ph == S_CMD) ? 2'b00 : st_r.wdata[17:16];
endmodule : store_sequencer
`default_nettype wire

// >>> testbench/guard_properties.sv
`timescale 1ns/1ps
`default_nettype none
module guard_properties
    import guard_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        req,
    input wire logic        write,
    input wire logic        isDma,
    input wire logic [31:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  wmask,
    input wire logic [1:0]  bitOp,
    input wire logic        ack,
    input wire logic [7:0]  rdata,
    input wire logic        irqHold
);
    // ====================
    // Store window checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_arm; req && write && !isDma && addr == CMD_ADDR; endsequence
    sequence s_store; req && write && !isDma && addr != CMD_ADDR; endsequence
    property p_ack; req |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_no_ack; !req |=> !ack; endproperty
    a_no_ack: assert property (p_no_ack) else $error("answer without request");
    property p_arm; s_arm |=> irqHold; endproperty
    a_arm: assert property (p_arm) else $error("command store did not block interrupts");
    property p_close; s_store |=> !irqHold; endproperty
    a_close: assert property (p_close) else $error("window open after a store");
    property p_hold; irqHold && !req |=> irqHold; endproperty
    a_hold: assert property (p_hold) else $error("window closed without a store");
    property p_idle; !irqHold && !req |=> !irqHold; endproperty
    a_idle: assert property (p_idle) else $error("window opened without a store");
    property p_read; req && !write |=> irqHold == $past(irqHold); endproperty
    a_read: assert property (p_read) else $error("read changed the window");
    property p_dma; req && isDma |=> irqHold == $past(irqHold); endproperty
    a_dma: assert property (p_dma) else $error("transfer store changed the window");
    property p_cmd_rd; req && !write && addr == CMD_ADDR |=> rdata == 8'h00; endproperty
    a_cmd_rd: assert property (p_cmd_rd) else $error("command read not zero");
endmodule : guard_properties
`default_nettype wire

// >>> testbench/tb_protected_register_write_guard.sv
`timescale 1ns/1ps
`default_nettype none
module tb_protected_register_write_guard;
    import guard_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, irq;
    logic        lockB = 1'b1;
    logic [7:0]  clkA, psA, clkB, psB, e;
    int          errors = 0;
    int          comparisons = 0;
    bitop_type   ops [4] = '{BOP_STORE, BOP_NOT, BOP_SET, BOP_CLEAR};
    periph_store_if busA ();
    periph_store_if busB ();
    always #12.5 sys_clk = ~sys_clk;
    store_sequencer i_store_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus(busA));
    protected_register_write_guard i_protected_register_write_guard (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(busA), .pllLockedPin(1'b1), .clockControl(clkA), .powerSaveControl(psA), .powerSaveWritten());
    // The second guard is driven directly so that faulty store orders can be produced.
    protected_register_write_guard i_protected_register_write_guard_b (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(busB), .pllLockedPin(lockB), .clockControl(clkB), .powerSaveControl(psB), .powerSaveWritten());
    guard_properties i_guard_properties (.sys_clk(sys_clk), .rst_n(rst_n), .req(busA.req), .write(busA.write),
        .isDma(busA.isDma), .addr(busA.addr), .wdata(busA.wdata), .wmask(busA.wmask), .bitOp(busA.bitOp),
        .ack(busA.ack), .rdata(busA.rdata), .irqHold(busA.irqHold));
    // ====================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge sys_clk);
    endtask : apb
    task automatic st(input logic wr, input logic dma, input logic [31:0] a, input logic [7:0] d,
                      input logic [7:0] m, input bitop_type op);
        @(posedge sys_clk);
        busB.req <= 1'b1;
        busB.write <= wr;
        busB.isDma <= dma;
        busB.addr <= a;
        busB.wdata <= d;
        busB.wmask <= m;
        busB.bitOp <= op;
        @(posedge sys_clk);
        busB.req <= 1'b0;
        @(negedge sys_clk);
        chk("ack", 32'h1, {31'h0, busB.ack});
        q = {24'h0, busB.rdata};
    endtask : st
    task automatic prot(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m, input bitop_type op);
        st(1'b1, 1'b0, CMD_ADDR, d, 8'h00, BOP_STORE);
        st(1'b1, 1'b0, a, d, m, op);
    endtask : prot
    task automatic stat(input logic [7:0] exp);
        st(1'b0, 1'b0, STATUS_ADDR, 8'h00, 8'h00, BOP_STORE);
        chk("status", {24'h0, exp}, q);
    endtask : stat
    // ====================
    // Tests
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        {busB.req, busB.write, busB.isDma, busB.addr, busB.wdata, busB.wmask} = '0;
        busB.bitOp = BOP_STORE;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("clock reset", {24'h0, CLKCTL_RESET}, {24'h0, clkB});
        stat(8'h00);
        prot(PSAVE_ADDR, 8'h04, 8'h00, BOP_STORE);
        chk("psave", 32'h04, {24'h0, psB});
        st(1'b0, 1'b0, PSAVE_ADDR, 8'h00, 8'h00, BOP_STORE);
        chk("psave read", 32'h04, q);
        e = CLKCTL_RESET;
        for (int i = 0; i < 4; i++) begin
            prot(CLKCTL_ADDR, 8'h3c, 8'h0f, ops[i]);
            case (ops[i])
                BOP_SET: e = e | 8'h0f;
                BOP_CLEAR: e = e & 8'hf0;
                BOP_NOT: e = e ^ 8'h0f;
                default: e = 8'h3c;
            endcase
            chk("clock", {24'h0, e}, {24'h0, clkB});
        end
        st(1'b1, 1'b0, CLKCTL_ADDR, 8'h77, 8'h00, BOP_STORE);
        chk("clock kept", {24'h0, e}, {24'h0, clkB});
        stat(8'h10);
        st(1'b1, 1'b0, STATUS_ADDR, 8'hff, 8'h00, BOP_STORE);
        stat(8'h10);
        st(1'b1, 1'b0, STATUS_ADDR, 8'h00, 8'h10, BOP_CLEAR);
        stat(8'h00);
        prot(STATUS_ADDR, 8'h00, 8'h00, BOP_STORE);
        stat(8'h10);
        st(1'b1, 1'b0, PSAVE_ADDR, 8'h0b, 8'h00, BOP_STORE);
        chk("psave kept", 32'h04, {24'h0, psB});
        st(1'b1, 1'b0, STATUS_ADDR, 8'h00, 8'h00, BOP_STORE);
        stat(8'h00);
        st(1'b1, 1'b0, CMD_ADDR, 8'hc3, 8'h00, BOP_STORE);
        st(1'b0, 1'b0, CMD_ADDR, 8'h00, 8'h00, BOP_STORE);
        st(1'b1, 1'b0, PSAVE_ADDR, 8'h01, 8'h00, BOP_STORE);
        chk("psave after read", 32'h01, {24'h0, psB});
        st(1'b1, 1'b1, PSAVE_ADDR, 8'h02, 8'h00, BOP_STORE);
        chk("psave transfer", 32'h01, {24'h0, psB});
        lockB <= 1'b0;
        repeat (4) @(posedge sys_clk);
        stat(8'h01);
        apb(1'b1, APB_ADDR, CLKCTL_ADDR);
        apb(1'b1, APB_WDATA, 32'h66);
        apb(1'b1, APB_IRQ_MASK, 32'h0);
        apb(1'b1, APB_CTRL, (32'h1 << CTRL_GO) | (32'h1 << CTRL_WRITE));
        q = 32'h1 << CTRL_BUSY;
        for (int n = 0; n < 50 && q[CTRL_BUSY] !== 1'b0; n++) apb(1'b0, APB_CTRL, 32'h0);
        chk("clock over apb", 32'h66, {24'h0, clkA});
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, APB_IRQ_MASK, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, APB_IRQ_STAT, 32'h3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, APB_IRQ_MASK, 32'h0);
        apb(1'b0, 12'h0ff, 32'h0);
        chk("unmapped", 32'h0, {31'h0, pslverr});
        close_out();
    end
endmodule : tb_protected_register_write_guard
`default_nettype wire
